// File: verilog/cid_regs.sv
// Chip identification register bank behind a classic Wishbone slave
//
// Summary of operation
// - All four registers are read-only; writes ignored
// - Maker register: code from bit five up, low 00011
// - Device code upper twelve, revision in bits 3:0
// - Memory capacity is four kilobytes per count
// - Memory kind code; this device reports 3h
// - Core voltage low byte 40h means 5 V
// - External supply high byte reads 00h
// - Values valid after flash init; internal boot immediate
// - Bits 15:14 drop low once flash is ready
// - Before ready: F040h memory, 0040h voltage register
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module cid_regs
  import cid_pkg::*;
#(
  // Arbitrary neutral identity values
  parameter logic [10:0] MAKER_CODE   = 11'h155,
  parameter logic [11:0] DEVICE_CODE  = 12'hABC,
  parameter logic [3:0]  REVISION     = 4'h1,
  parameter logic [9:0]  MEM_CAPACITY = 10'h020
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [17:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // Boot and flash status
  input  wire logic        external_access_pin,
  input  wire logic        flash_init_done,
  output var  logic        id_valid
);

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  logic ea_level;
  logic init_level;

  cid_sync u_sync_ea (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .pin_in    (external_access_pin),
    .level_out (ea_level)
  );

  cid_sync u_sync_init (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .pin_in    (flash_init_done),
    .level_out (init_level)
  );

  // ----------------------------------------------------------------------
  // Boot strap capture and readiness
  // ----------------------------------------------------------------------
  // Strap is sampled during reset by a clocked process, never as a reset value
  logic boot_internal;
  logic ready;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      boot_internal <= ea_level;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ready <= 1'b0;
    end else if (boot_internal || init_level) begin
      ready <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      id_valid <= 1'b0;
    end else begin
      id_valid <= ready;
    end
  end

  // ----------------------------------------------------------------------
  // Register contents
  // ----------------------------------------------------------------------
  logic [15:0] maker_id;
  logic [15:0] device_revision_id;
  logic [15:0] memory_kind_size_id;
  logic [15:0] programming_voltage_id;

  always_comb begin
    maker_id = {MAKER_CODE, CID_MAKER_LOW_BITS};
    device_revision_id = {DEVICE_CODE, REVISION};
    if (ready) begin
      memory_kind_size_id = {2'b00, CID_KIND_HP_FLASH, MEM_CAPACITY};
      programming_voltage_id = {CID_EXT_SUPPLY, CID_CORE_VOLT_5V};
    end else begin
      memory_kind_size_id = CID_MEM_KIND_EARLY;
      programming_voltage_id = CID_PROG_VOLT_EARLY;
    end
  end

  // ----------------------------------------------------------------------
  // Wishbone slave: one wait state, ack for one cycle
  // ----------------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    case (wb_adr_i)
      CID_ADR_MAKER:     next_rdata = {16'h0000, maker_id};
      CID_ADR_DEV_REV:   next_rdata = {16'h0000, device_revision_id};
      CID_ADR_MEM_KIND:  next_rdata = {16'h0000, memory_kind_size_id};
      CID_ADR_PROG_VOLT: next_rdata = {16'h0000, programming_voltage_id};
      default:           next_rdata = CID_UNMAPPED_READ;
    endcase
  end

  // Writes are acknowledged but have no target, so contents never change
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Read path only samples; nothing is updated by a read
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
      wb_dat_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_ack_pulse: assert property (@(posedge ref_clk) disable iff (reset)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_ack_timing: assert property (@(posedge ref_clk) disable iff (reset)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing one cycle after request");

  a_maker_low: assert property (@(posedge ref_clk) disable iff (reset)
    (wb_ack_o && $past(wb_adr_i) == CID_ADR_MAKER && !$past(wb_we_i)) |-> wb_dat_o[4:0] == 5'h03)
    else $error("maker low bits wrong");

  a_dev_rev: assert property (@(posedge ref_clk) disable iff (reset)
    (wb_ack_o && $past(wb_adr_i) == CID_ADR_DEV_REV && !$past(wb_we_i)) |-> wb_dat_o[3:0] == REVISION)
    else $error("revision field wrong");

  a_mem_kind: assert property (@(posedge ref_clk) disable iff (reset)
    (wb_ack_o && $past(ready) && $past(wb_adr_i) == CID_ADR_MEM_KIND && !$past(wb_we_i))
      |-> wb_dat_o[13:10] == 4'h3)
    else $error("memory kind not 3h");

  a_volt_ready: assert property (@(posedge ref_clk) disable iff (reset)
    (wb_ack_o && $past(ready) && $past(wb_adr_i) == CID_ADR_PROG_VOLT && !$past(wb_we_i))
      |-> wb_dat_o[15:0] == 16'h0040)
    else $error("voltage register wrong");

  a_busy_bits: assert property (@(posedge ref_clk) disable iff (reset)
    (wb_ack_o && $past(wb_adr_i) == CID_ADR_MEM_KIND && !$past(wb_we_i))
      |-> (wb_dat_o[15:14] == 2'b00) == $past(ready))
    else $error("busy bits disagree with readiness");

  a_early_mem: assert property (@(posedge ref_clk) disable iff (reset)
    (wb_ack_o && !$past(ready) && $past(wb_adr_i) == CID_ADR_MEM_KIND && !$past(wb_we_i))
      |-> wb_dat_o[15:0] == 16'hF040)
    else $error("early memory value wrong");

  a_early_volt: assert property (@(posedge ref_clk) disable iff (reset)
    (wb_ack_o && !$past(ready) && $past(wb_adr_i) == CID_ADR_PROG_VOLT && !$past(wb_we_i))
      |-> wb_dat_o[15:0] == 16'h0040)
    else $error("early voltage value wrong");

  a_ready_sticky: assert property (@(posedge ref_clk) disable iff (reset)
    ready |=> ready)
    else $error("readiness lost");

  a_valid_follow: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(ready) |=> id_valid)
    else $error("valid flag late");

  c_read_early: cover property (@(posedge ref_clk) disable iff (reset)
    wb_ack_o && !ready && !$past(wb_we_i));
  c_read_ready: cover property (@(posedge ref_clk) disable iff (reset)
    wb_ack_o && ready && !$past(wb_we_i));
  c_write: cover property (@(posedge ref_clk) disable iff (reset)
    wb_ack_o && $past(wb_we_i));
  c_becomes_ready: cover property (@(posedge ref_clk) disable iff (reset)
    $rose(ready));

endmodule : cid_regs
`default_nettype wire

// File: verilog/cid_pkg.sv
// Package: constants for the chip identification register bank
package cid_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses on the Wishbone slave
  // ----------------------------------------------------------------------
  // Printed offsets are not all multiples of four, so they stand as indices
  localparam logic [15:0] CID_IDX_PROG_VOLT = 16'hF078;
  localparam logic [15:0] CID_IDX_DEV_REV   = 16'hF07C;
  localparam logic [15:0] CID_IDX_MAKER     = 16'hF07E;
  localparam logic [15:0] CID_IDX_MEM_KIND  = 16'hF07A;
  localparam int          CID_ADR_W         = 18;
  localparam logic [17:0] CID_ADR_PROG_VOLT = {CID_IDX_PROG_VOLT, 2'b00};
  localparam logic [17:0] CID_ADR_DEV_REV   = {CID_IDX_DEV_REV, 2'b00};
  localparam logic [17:0] CID_ADR_MAKER     = {CID_IDX_MAKER, 2'b00};
  localparam logic [17:0] CID_ADR_MEM_KIND  = {CID_IDX_MEM_KIND, 2'b00};

  // ----------------------------------------------------------------------
  // Field layouts and values
  // ----------------------------------------------------------------------
  localparam int          CID_MAKER_CODE_LSB = 5;
  localparam logic [4:0]  CID_MAKER_LOW_BITS = 5'h03;
  localparam int          CID_DEV_CODE_LSB   = 4;
  localparam int          CID_MEM_BUSY_HI    = 15;
  localparam int          CID_MEM_BUSY_LO    = 14;
  localparam int          CID_MEM_KIND_LSB   = 10;
  localparam logic [3:0]  CID_KIND_NONE      = 4'h0;
  localparam logic [3:0]  CID_KIND_MASK_ROM  = 4'h1;
  localparam logic [3:0]  CID_KIND_STD_FLASH = 4'h2;
  localparam logic [3:0]  CID_KIND_HP_FLASH  = 4'h3;
  localparam logic [7:0]  CID_CORE_VOLT_5V   = 8'h40;
  localparam logic [7:0]  CID_EXT_SUPPLY     = 8'h00;

  // ----------------------------------------------------------------------
  // Values shown before the flash is ready
  // ----------------------------------------------------------------------
  localparam logic [15:0] CID_MEM_KIND_EARLY  = 16'hF040;
  localparam logic [15:0] CID_PROG_VOLT_EARLY = 16'h0040;
  localparam logic [31:0] CID_UNMAPPED_READ   = 32'h00000000;

endpackage : cid_pkg

// File: verilog/cid_sync.sv
// Three-stage synchroniser with a two-stage agreement filter
`timescale 1ns/100ps
`default_nettype none
module cid_sync (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Pin in, filtered level out
  input  wire logic pin_in,
  output var  logic level_out
);
  logic [2:0] stage;

  // Stages keep shifting in reset so a boot strap can be seen while reset is held
  always_ff @(posedge ref_clk) begin
    stage <= {stage[1:0], pin_in};
  end

  // Only stages two and three are compared; the first one is left alone
  // In reset the level follows the last stage so the strap is captured
  always_ff @(posedge ref_clk) begin
    if (reset || (stage[1] == stage[2])) begin
      level_out <= stage[2];
    end
  end
endmodule : cid_sync
`default_nettype wire

// File: test/tb_chip_identification_regs.sv
// Self-checking bench for the chip identification register bank
`timescale 1ns/100ps
`default_nettype none
module tb_chip_identification_regs
  import cid_pkg::*;
;
  // ----------------------------------------------------------------------
  // Identity values, arbitrary and neutral
  // ----------------------------------------------------------------------
  localparam logic [10:0] MK = 11'h2B5;
  localparam logic [11:0] DV = 12'h5A7;
  localparam logic [3:0]  RV = 4'h6;
  localparam logic [9:0]  MC = 10'h020;

  logic        ref_clk, reset, cyc, stb, we, ext_pin, fl_done;
  logic [17:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q, rnd;
  logic        ack, id_valid;
  logic [17:0] regs [4];
  logic [17:0] ra;
  int          fails, num_checks, n;

  cid_regs #(.MAKER_CODE(MK), .DEVICE_CODE(DV), .REVISION(RV), .MEM_CAPACITY(MC)) cid_regs_i (
    .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .external_access_pin(ext_pin), .flash_init_done(fl_done), .id_valid(id_valid));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  // Upper half of every word reads zero; unmapped places read zero
  function automatic logic [31:0] exp_reg(input logic [17:0] a, input logic rdy);
    case (a)
      CID_ADR_MAKER:     return {16'h0000, MK, 5'h03};
      CID_ADR_DEV_REV:   return {16'h0000, DV, RV};
      CID_ADR_MEM_KIND:  return rdy ? {16'h0000, 2'b00, 4'h3, MC} : 32'h0000F040;
      CID_ADR_PROG_VOLT: return 32'h00000040;
      default:           return 32'h00000000;
    endcase
  endfunction : exp_reg

  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_data

  task automatic cmp_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t flag got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_flag

  // Classic cycle: hold everything until ack is sampled, then drop for a cycle
  task automatic wb_xfer(input logic w, input logic [17:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= rnd[7:4];
    do begin
      @(posedge ref_clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = rdat;
    if (k >= 50) fails++;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb_xfer

  task automatic rd_chk(input logic [17:0] a, input logic rdy);
    wb_xfer(1'b0, a, 32'h0);
    cmp_data(q, exp_reg(a, rdy));
  endtask : rd_chk

  task automatic do_reset(input logic strap);
    @(posedge ref_clk);
    reset <= 1'b1; ext_pin <= strap; fl_done <= 1'b0;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
  endtask : do_reset

  task automatic print_verdict();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------------
  // Clock, watchdog, main sequence
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (4000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end

  initial begin
    reset = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; sel = '0; wdat = '0;
    ext_pin = 1'b0; fl_done = 1'b0; rnd = 32'hC0FC24C4; fails = 0; num_checks = 0;
    regs = '{CID_ADR_MAKER, CID_ADR_DEV_REV, CID_ADR_MEM_KIND, CID_ADR_PROG_VOLT};
    // External boot: values not yet valid
    do_reset(1'b0);
    rd_chk(CID_ADR_MEM_KIND, 1'b0);
    rd_chk(CID_ADR_PROG_VOLT, 1'b0);
    cmp_flag(id_valid, 1'b0);
    wb_xfer(1'b1, CID_ADR_MEM_KIND, 32'h00000000);
    rd_chk(CID_ADR_MEM_KIND, 1'b0);
    rd_chk(CID_ADR_MEM_KIND, 1'b0);
    @(posedge ref_clk);
    fl_done <= 1'b1;
    // Software polls until both busy bits read low
    n = 0;
    do begin
      wb_xfer(1'b0, CID_ADR_MEM_KIND, 32'h0);
      n++;
    end while (q[15:14] !== 2'b00 && n < 20);
    cmp_data(q, exp_reg(CID_ADR_MEM_KIND, 1'b1));
    cmp_flag(id_valid, 1'b1);
    // Random writes to mapped registers; reads mapped and unmapped
    for (int i = 0; i < 60; i++) begin
      rnd = xs(rnd);
      ra = rnd[8] ? regs[rnd[1:0]] : rnd[31:14];
      if (rnd[9]) wb_xfer(1'b1, regs[rnd[3:2]], xs(rnd));
      rd_chk(regs[rnd[3:2]], 1'b1);
      rd_chk(ra, 1'b1);
    end
    // Internal boot: values valid straight after reset
    do_reset(1'b1);
    repeat (3) @(posedge ref_clk);
    cmp_flag(id_valid, 1'b1);
    for (int i = 0; i < 4; i++)
      rd_chk(regs[i], 1'b1);
    print_verdict();
  end
endmodule : tb_chip_identification_regs
`default_nettype wire
